// ---- design/rdm_pkg.sv ----
// package: register map, field positions, reset values and states of the dma manager
package rdm_pkg;
  localparam logic [6:0]  REG_CSR_MAIN   = 7'h00;
  localparam logic [6:0]  REG_SETUP_LO   = 7'h01;
  localparam logic [6:0]  REG_SETUP_HI   = 7'h02;
  localparam logic [6:0]  REG_FEATURE    = 7'h04;
  localparam logic [6:0]  REG_MODE       = 7'h0F;
  localparam logic [6:0]  REG_TX_BASE_LO = 7'h1E;
  localparam logic [6:0]  REG_TX_BASE_HI = 7'h1F;
  localparam logic [6:0]  REG_RX_BASE_LO = 7'h18;
  localparam logic [6:0]  REG_RX_BASE_HI = 7'h19;
  localparam logic [6:0]  REG_TX_CUR_LO  = 7'h22;
  localparam logic [6:0]  REG_RX_CUR_LO  = 7'h1C;
  localparam logic [6:0]  REG_TX_RX_RING_LENGTH_CODE    = 7'h4C;
  localparam logic [6:0]  REG_RX_RX_RING_LENGTH_CODE    = 7'h4E;
  localparam logic [6:0]  REG_BURST_LIM  = 7'h50;
  localparam logic [6:0]  REG_DMA_REQ    = 7'h60;
  // main control/status, feature and mode bit positions
  localparam int B_SETUP_REQ  = 0;
  localparam int B_RUN        = 1;
  localparam int B_HALT       = 2;
  localparam int B_TX_ACT     = 4;
  localparam int B_RX_ACT     = 5;
  localparam int B_IRQ_EN     = 6;
  localparam int B_IRQ_PEND   = 7;
  localparam int B_SETUP_DONE = 8;
  localparam int B_MEM_ERR    = 11;
  localparam int B_EXT_BURST  = 14;
  localparam int B_TX_DIS     = 0;
  localparam int B_RX_DIS     = 1;
  localparam logic [15:0] BURST_LIM_RST  = 16'h0010;
  localparam logic [15:0] MODE_RST       = 16'h0000;
  localparam logic [15:0] MAIN_RST       = 16'h0004;
  localparam logic [3:0]  SETUP_WORDS    = 4'hC;
  localparam logic [2:0]  SETUP_PER_GRANT = 3'h4;
  localparam logic [23:0] DESC_BYTES     = 24'h000008;
  localparam logic [7:0]  TX_HI_THRESH   = 8'h20;
  localparam logic [7:0]  RX_LO_THRESH   = 8'h10;
  localparam logic [7:0]  RING_LEN_MAX_SETUP = 8'h80;
  localparam logic [1:0]  WAIT_CYCLES    = 2'h2;
  // dma request kinds in the request register
  localparam logic [1:0]  K_DESC  = 2'h1;
  localparam logic [1:0]  K_BURST = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_REQ   = 3'b001,
    ST_XFER  = 3'b011,
    ST_REL   = 3'b010,
    ST_APPLY = 3'b110
  } rdm_state_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [1:0]  bsel_n;
    logic        wr;
    logic        rd;
  } rdm_mcyc_t;
endpackage

// ---- design/rdm_top.sv ----
// dma engine and ring buffer manager of the host bus unit
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module rdm_top
  import rdm_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        slv_sel_i,
  output logic             iochrdy_o,
  input  wire logic        bus_grant_i,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_err_i,
  input  wire logic        tx_transmit_underflow_flag_i,
  input  wire logic        tx_transmit_buffer_error_err_i,
  input  wire logic [7:0]  fifo_level_i,
  output logic             bus_req_o,
  output var rdm_mcyc_t    mcyc_o,
  output logic      [15:0] mem_wdata_o,
  output logic             irq_o
);
  logic [15:0] main_r, setlo_r, sethi_r, feat_r, mode_r, blim_r;
  logic [15:0] txlen_r, rxlen_r, dreq_r;
  logic [23:0] txbase_r, rxbase_r, txcur_r, rxcur_r, txnext_r, rxnext_r;
  logic [15:0] txidx_r, rxidx_r;
  rdm_state_t  st_r;
  logic [3:0]  sw_cnt_r;
  logic [2:0]  grp_cnt_r;
  logic [15:0] xfer_cnt_r;
  logic [23:0] xaddr_r;
  logic        kind_setup_r, dwr_r, dbyte_r;
  logic [1:0]  dkind_r;
  logic [15:0] setup_mem_r [0:11];
  // grant and ack pass a two-flop synchroniser before the sequencer reads them
  logic        grant_q, grant_qq, ack_q, ack_qq;
  logic        halted_seen_r, mode_wr_seen_r;
  logic [1:0]  wait_cnt_r;
  logic        wait_r;
  logic        tx_act_r, rx_act_r;

  // address of the descriptor following ptr in a ring of len entries
  function automatic logic [23:0] ring_next(input logic [23:0] base, input logic [15:0] idx,
                                            input logic [15:0] len, input logic [23:0] ptr);
    ring_next = ((idx + 16'h0001) >= len) ? base : ptr + DESC_BYTES;
  endfunction

  // grant and ack are from outside and pass two flops first
  always_ff @(posedge clk_sys_i) begin
    grant_q  <= bus_grant_i;
    grant_qq <= grant_q;
    ack_q    <= mem_ack_i;
    ack_qq   <= ack_q;
  end
  wire ack_ok = ack_qq;
  wire run_wr   = reg_wr_i && reg_addr_i == REG_CSR_MAIN && reg_wdata_i[B_RUN];
  wire halt_wr  = reg_wr_i && reg_addr_i == REG_CSR_MAIN && reg_wdata_i[B_HALT];
  wire setup_wr = reg_wr_i && reg_addr_i == REG_CSR_MAIN && reg_wdata_i[B_SETUP_REQ];
  wire err_any  = mem_err_i | tx_transmit_underflow_flag_i | tx_transmit_buffer_error_err_i;
  wire applying = st_r == ST_APPLY;

  // burst end: counted limit or fifo threshold
  wire ext_burst = feat_r[B_EXT_BURST];
  wire burst_end = ext_burst ?
                   (dwr_r ? fifo_level_i <= RX_LO_THRESH : fifo_level_i >= TX_HI_THRESH)
                   : (xfer_cnt_r + 16'h0001 >= blim_r);

  // master sequencer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      sw_cnt_r <= 4'h0;
      grp_cnt_r <= 3'h0;
      xfer_cnt_r <= 16'h0000;
      xaddr_r <= 24'h000000;
      kind_setup_r <= 1'b0;
      dkind_r <= 2'h0;
      dwr_r <= 1'b0;
      dbyte_r <= 1'b0;
      bus_req_o <= 1'b0;
      mcyc_o <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (setup_wr) begin
            kind_setup_r <= 1'b1;
            sw_cnt_r <= 4'h0;
            xaddr_r <= {reg_wdata_i[B_SETUP_REQ] ? sethi_r[7:0] : 8'h00, setlo_r};
            bus_req_o <= 1'b1;
            st_r <= ST_REQ;
          end else if (reg_wr_i && reg_addr_i == REG_DMA_REQ &&
                       (reg_wdata_i[1:0] == K_DESC || reg_wdata_i[1:0] == K_BURST)) begin
            kind_setup_r <= 1'b0;
            dkind_r <= reg_wdata_i[1:0];
            dwr_r <= reg_wdata_i[2];
            dbyte_r <= reg_wdata_i[3];
            xaddr_r <= reg_wdata_i[4] ? rxcur_r : txcur_r;
            bus_req_o <= 1'b1;
            st_r <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (grant_qq) begin
            grp_cnt_r <= 3'h0;
            xfer_cnt_r <= 16'h0000;
            mcyc_o.addr <= xaddr_r;
            mcyc_o.bsel_n <= dbyte_r && !kind_setup_r ? {~xaddr_r[0], xaddr_r[0]} : 2'b00;
            mcyc_o.rd <= kind_setup_r | ~dwr_r;
            mcyc_o.wr <= ~kind_setup_r & dwr_r;
            st_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (ack_ok) begin
            xaddr_r <= xaddr_r + 24'h000002;
            mcyc_o.addr <= xaddr_r + 24'h000002;
            xfer_cnt_r <= xfer_cnt_r + 16'h0001;
            if (kind_setup_r) begin
              sw_cnt_r <= sw_cnt_r + 4'h1;
              grp_cnt_r <= grp_cnt_r + 3'h1;
              if (grp_cnt_r + 3'h1 == SETUP_PER_GRANT) begin
                mcyc_o.rd <= 1'b0;
                bus_req_o <= 1'b0;
                st_r <= ST_REL;
              end
            end else if (dkind_r == K_DESC || burst_end) begin
              mcyc_o.rd <= 1'b0;
              mcyc_o.wr <= 1'b0;
              bus_req_o <= 1'b0;
              st_r <= ST_REL;
            end
          end
        end
        ST_REL: begin
          if (!grant_qq) begin
            if (kind_setup_r && sw_cnt_r != SETUP_WORDS) begin
              bus_req_o <= 1'b1;  // next group of four
              st_r <= ST_REQ;
            end else begin
              st_r <= kind_setup_r ? ST_APPLY : ST_IDLE;
            end
          end
        end
        ST_APPLY: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // setup words captured in arrival order
  always_ff @(posedge clk_sys_i) begin
    if (st_r == ST_XFER && ack_ok && kind_setup_r && sw_cnt_r < SETUP_WORDS)
      setup_mem_r[sw_cnt_r] <= mem_rdata_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i)
      mem_wdata_o <= 16'h0000;
    else if (reg_wr_i && reg_addr_i == REG_DMA_REQ)
      mem_wdata_o <= {12'h000, reg_wdata_i[15:12]};
  end

  // registers written by software or loaded by setup fetch
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      setlo_r <= 16'h0000;
      sethi_r <= 16'h0000;
      feat_r <= 16'h0000;
      mode_r <= MODE_RST;
      blim_r <= BURST_LIM_RST;
      txlen_r <= 16'h0001;
      rxlen_r <= 16'h0001;
      txbase_r <= 24'h000000;
      rxbase_r <= 24'h000000;
      dreq_r <= 16'h0000;
    end else if (applying) begin
      mode_r <= setup_mem_r[0];
      rxbase_r <= {setup_mem_r[9][7:0], setup_mem_r[8][15:3], 3'b000};
      txbase_r <= {setup_mem_r[11][7:0], setup_mem_r[10][15:3], 3'b000};
      // ring length is a power-of-two code, capped at 128 entries
      rxlen_r <= (16'h0001 << setup_mem_r[9][15:13]) > {8'h00, RING_LEN_MAX_SETUP} ?
                 {8'h00, RING_LEN_MAX_SETUP} : 16'h0001 << setup_mem_r[9][15:13];
      txlen_r <= (16'h0001 << setup_mem_r[11][15:13]) > {8'h00, RING_LEN_MAX_SETUP} ?
                 {8'h00, RING_LEN_MAX_SETUP} : 16'h0001 << setup_mem_r[11][15:13];
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        REG_SETUP_LO:   setlo_r <= reg_wdata_i;
        REG_SETUP_HI:   sethi_r <= {8'h00, reg_wdata_i[7:0]};
        REG_FEATURE:    feat_r <= reg_wdata_i;
        REG_MODE:       mode_r <= reg_wdata_i;
        REG_BURST_LIM:  blim_r <= reg_wdata_i;
        REG_TX_RX_RING_LENGTH_CODE:    txlen_r <= reg_wdata_i;
        REG_RX_RX_RING_LENGTH_CODE:    rxlen_r <= reg_wdata_i;
        REG_TX_BASE_LO: txbase_r[15:0] <= {reg_wdata_i[15:3], 3'b000};
        REG_TX_BASE_HI: txbase_r[23:16] <= reg_wdata_i[7:0];
        REG_RX_BASE_LO: rxbase_r[15:0] <= {reg_wdata_i[15:3], 3'b000};
        REG_RX_BASE_HI: rxbase_r[23:16] <= reg_wdata_i[7:0];
        REG_DMA_REQ:    dreq_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // halt then mode write then run is a restart
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      halted_seen_r <= 1'b0;
      mode_wr_seen_r <= 1'b0;
    end else if (halt_wr) begin
      halted_seen_r <= 1'b1;
      mode_wr_seen_r <= 1'b0;
    end else if (run_wr) begin
      halted_seen_r <= 1'b0;
      mode_wr_seen_r <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == REG_MODE && halted_seen_r) begin
      mode_wr_seen_r <= 1'b1;
    end
  end

  // descriptor pointers: any run start reloads bases, which covers restart too
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      txcur_r <= 24'h000000;
      rxcur_r <= 24'h000000;
      txnext_r <= 24'h000000;
      rxnext_r <= 24'h000000;
      txidx_r <= 16'h0000;
      rxidx_r <= 16'h0000;
    end else if (run_wr) begin
      txcur_r <= txbase_r;
      rxcur_r <= rxbase_r;
      txidx_r <= 16'h0000;
      rxidx_r <= 16'h0000;
      txnext_r <= ring_next(txbase_r, 16'h0000, txlen_r, txbase_r);
      rxnext_r <= ring_next(rxbase_r, 16'h0000, rxlen_r, rxbase_r);
    end else if (reg_wr_i && reg_addr_i == REG_DMA_REQ && reg_wdata_i[5]) begin
      // handing a descriptor back advances that ring
      if (reg_wdata_i[4]) begin
        rxcur_r <= rxnext_r;
        rxidx_r <= (rxidx_r + 16'h0001 >= rxlen_r) ? 16'h0000 : rxidx_r + 16'h0001;
        rxnext_r <= ring_next(rxbase_r, (rxidx_r + 16'h0001 >= rxlen_r) ? 16'h0000 :
                              rxidx_r + 16'h0001, rxlen_r, rxnext_r);
      end else begin
        txcur_r <= txnext_r;
        txidx_r <= (txidx_r + 16'h0001 >= txlen_r) ? 16'h0000 : txidx_r + 16'h0001;
        txnext_r <= ring_next(txbase_r, (txidx_r + 16'h0001 >= txlen_r) ? 16'h0000 :
                              txidx_r + 16'h0001, txlen_r, txnext_r);
      end
    end
  end

  // section activity; memory errors stop both, tx errors stop only tx, each winning over a run in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_act_r <= 1'b0;
      rx_act_r <= 1'b0;
    end else begin
      if (mem_err_i || tx_transmit_underflow_flag_i || tx_transmit_buffer_error_err_i || halt_wr)
        tx_act_r <= 1'b0;
      else if (run_wr)
        tx_act_r <= ~mode_r[B_TX_DIS];
      if (mem_err_i || halt_wr)
        rx_act_r <= 1'b0;
      else if (run_wr)
        rx_act_r <= ~mode_r[B_RX_DIS];
    end
  end

  // main status: set wins over write-one-to-clear
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      main_r <= MAIN_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_CSR_MAIN) begin
        main_r[B_IRQ_EN] <= reg_wdata_i[B_IRQ_EN];
        if (reg_wdata_i[B_SETUP_DONE]) main_r[B_SETUP_DONE] <= 1'b0;
        if (reg_wdata_i[B_MEM_ERR]) main_r[B_MEM_ERR] <= 1'b0;
        if (halt_wr) main_r[B_HALT] <= 1'b1;
        else if (run_wr || setup_wr) main_r[B_HALT] <= 1'b0;
      end
      main_r[B_SETUP_REQ] <= setup_wr | (main_r[B_SETUP_REQ] & ~applying);
      if (applying) main_r[B_SETUP_DONE] <= 1'b1;
      if (mem_err_i) main_r[B_MEM_ERR] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= main_r[B_IRQ_EN] & (main_r[B_SETUP_DONE] | main_r[B_MEM_ERR]);
  end

  // slave wait: ready dropped at once by select, freed on a clock edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wait_cnt_r <= 2'h0;
      wait_r <= 1'b0;
    end else if (slv_sel_i && !wait_r && wait_cnt_r == 2'h0) begin
      wait_r <= 1'b1;
      wait_cnt_r <= WAIT_CYCLES;
    end else if (wait_cnt_r != 2'h0) begin
      wait_cnt_r <= wait_cnt_r - 2'h1;
    end else if (!slv_sel_i) begin
      wait_r <= 1'b0;
    end
  end
  // the asynchronous pull-down is intended here, so this output is not registered
  assign iochrdy_o = ~((slv_sel_i & ~wait_r) | (wait_r & wait_cnt_r != 2'h0));

  // register read, one cycle later
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CSR_MAIN: reg_rdata_o <= {main_r[15:8], irq_o, main_r[B_IRQ_EN], rx_act_r,
                                      tx_act_r, main_r[3:0]};
        REG_SETUP_LO:   reg_rdata_o <= setlo_r;
        REG_SETUP_HI:   reg_rdata_o <= sethi_r;
        REG_FEATURE:    reg_rdata_o <= feat_r;
        REG_MODE:       reg_rdata_o <= mode_r;
        REG_BURST_LIM:  reg_rdata_o <= blim_r;
        REG_TX_RX_RING_LENGTH_CODE:    reg_rdata_o <= txlen_r;
        REG_RX_RX_RING_LENGTH_CODE:    reg_rdata_o <= rxlen_r;
        REG_TX_BASE_LO: reg_rdata_o <= txbase_r[15:0];
        REG_TX_BASE_HI: reg_rdata_o <= {8'h00, txbase_r[23:16]};
        REG_RX_BASE_LO: reg_rdata_o <= rxbase_r[15:0];
        REG_RX_BASE_HI: reg_rdata_o <= {8'h00, rxbase_r[23:16]};
        REG_TX_CUR_LO:  reg_rdata_o <= txcur_r[15:0];
        REG_RX_CUR_LO:  reg_rdata_o <= rxcur_r[15:0];
        REG_DMA_REQ:    reg_rdata_o <= {dreq_r[15:3], mode_wr_seen_r, st_r[1:0]};
        default:        reg_rdata_o <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- bench/rdm_top_sva.sv ----
// port-level assertion checker for the dma manager
`timescale 1ns/100ps
`default_nettype none
module rdm_top_sva
  import rdm_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_rdata_o,
  input  wire logic        slv_sel_i,
  input  wire logic        iochrdy_o,
  input  wire logic        mem_ack_i,
  input  wire logic        bus_req_o,
  input  wire rdm_mcyc_t   mcyc_o,
  input  wire logic        irq_o
);
  logic [15:0] lim_r;
  logic        ext_r;
  logic        ien_r;
  logic [15:0] xfer_cnt_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of software settings, needed to judge burst length and interrupt masking
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lim_r <= BURST_LIM_RST;
      ext_r <= 1'b0;
      ien_r <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == REG_BURST_LIM) lim_r <= reg_wdata_i;
      if (reg_addr_i == REG_FEATURE) ext_r <= reg_wdata_i[B_EXT_BURST];
      if (reg_addr_i == REG_CSR_MAIN) ien_r <= reg_wdata_i[B_IRQ_EN];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !bus_req_o) xfer_cnt_r <= 16'h0000;
    else if (mem_ack_i) xfer_cnt_r <= xfer_cnt_r + 16'h0001;
  end
  AST_RESET_QUIET: assert property ($rose(rst_n_i) |-> !bus_req_o && !irq_o) // [RESET]
    else $error("outputs not quiet after reset");
  AST_ONE_DIR: assert property (!(mcyc_o.rd && mcyc_o.wr))
    else $error("read and write at once");
  AST_DIR_HOLD: assert property (bus_req_o && $past(bus_req_o) |->
    !(mcyc_o.rd && $past(mcyc_o.wr)) && !(mcyc_o.wr && $past(mcyc_o.rd)))
    else $error("direction changed within mastership");
  AST_ADDR_STEP: assert property (bus_req_o && $past(bus_req_o) && (mcyc_o.rd || mcyc_o.wr)
    && ($past(mcyc_o.rd) || $past(mcyc_o.wr)) && $changed(mcyc_o.addr)
    |-> mcyc_o.addr == $past(mcyc_o.addr) + 24'h000002)
    else $error("burst address not contiguous");
  AST_BURST_LIMIT: assert property (!ext_r |-> xfer_cnt_r <= lim_r)
    else $error("burst exceeded limit");
  AST_WAIT_NOW: assert property (slv_sel_i && !$past(slv_sel_i) |-> !iochrdy_o ##[1:4] iochrdy_o)
    else $error("wait state not taken or not released");
  AST_IDLE_READY: assert property (!slv_sel_i |-> iochrdy_o)
    else $error("ready low while unselected");
  AST_RDATA_HOLD: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o)) // [RESET]
    else $error("read data moved without read");
  AST_IRQ_MASKED: assert property (!ien_r && !$past(ien_r) |-> !irq_o)
    else $error("interrupt while disabled");
  AST_SETUP_REQ: assert property (reg_wr_i && reg_addr_i == REG_CSR_MAIN && !bus_req_o
    && reg_wdata_i[B_SETUP_REQ] |-> ##[1:3] bus_req_o)
    else $error("setup request did not ask for the bus");
  cover property ($rose(bus_req_o));
  cover property ($rose(irq_o));
  cover property (!iochrdy_o);
endmodule
bind rdm_top rdm_top_sva u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .slv_sel_i(slv_sel_i),
  .iochrdy_o(iochrdy_o), .mem_ack_i(mem_ack_i), .bus_req_o(bus_req_o),
  .mcyc_o(mcyc_o), .irq_o(irq_o));
`default_nettype wire

// ---- bench/rdm_host_mem.sv ----
// behavioural host memory and arbiter facing the dma master
`timescale 1ns/100ps
`default_nettype none
module rdm_host_mem
  import rdm_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        slow_i,
  input  wire logic        bus_req_i,
  input  wire rdm_mcyc_t   mcyc_i,
  output logic             bus_grant_o,
  output logic             mem_ack_o,
  output logic      [15:0] mem_rdata_o
);
  logic [3:0] gap_r;
  // all decisions on the shared clock edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_grant_o <= 1'b0;
      mem_ack_o   <= 1'b0;
      gap_r       <= 4'h0;
      mem_rdata_o <= 16'hFFFF;
    end else begin
      bus_grant_o <= bus_req_i;
      mem_ack_o   <= 1'b0;
      if (gap_r != 4'h0) gap_r <= gap_r - 4'h1;
      // data held past the sync delay, then it wanders
      if (gap_r != 4'h0 && gap_r <= 4'h3) mem_rdata_o <= ~mem_rdata_o;
      if (gap_r == 4'h0 && bus_grant_o && bus_req_i && (mcyc_i.rd || mcyc_i.wr)) begin
        mem_ack_o   <= 1'b1;
        mem_rdata_o <= mcyc_i.addr[15:0] ^ 16'h5A5A;
        gap_r       <= slow_i ? 4'hC : 4'h6;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the dma manager
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rdm_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [6:0]  reg_addr_i = 7'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        slv_sel_i = 1'b0;
  logic        mem_err_i = 1'b0;
  logic        tx_transmit_underflow_flag_i = 1'b0;
  logic        tx_transmit_buffer_error_err_i = 1'b0;
  logic [7:0]  fifo_level_i = 8'h20;
  logic        slow = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [15:0] mem_rdata_i;
  logic [15:0] mem_wdata_o;
  logic        iochrdy_o;
  logic        bus_grant_i;
  logic        mem_ack_i;
  logic        bus_req_o;
  logic        irq_o;
  logic        req_q = 1'b0;
  rdm_mcyc_t   mcyc_o;
  logic [23:0] xa_q[$];
  logic [15:0] d;
  int          grants = 0;
  int          wrs = 0;
  int          cyc = 0;
  int          n;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  rdm_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .slv_sel_i(slv_sel_i), .iochrdy_o(iochrdy_o),
    .bus_grant_i(bus_grant_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .mem_err_i(mem_err_i), .tx_transmit_underflow_flag_i(tx_transmit_underflow_flag_i), .tx_transmit_buffer_error_err_i(tx_transmit_buffer_error_err_i),
    .fifo_level_i(fifo_level_i), .bus_req_o(bus_req_o), .mcyc_o(mcyc_o),
    .mem_wdata_o(mem_wdata_o), .irq_o(irq_o));
  rdm_host_mem u_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .bus_req_i(bus_req_o), .mcyc_i(mcyc_o), .bus_grant_o(bus_grant_i),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // monitor: grants and every acknowledged transfer
  always @(posedge clk_sys_i) begin
    req_q <= bus_req_o;
    cyc++;
    if (bus_req_o && !req_q) grants++;
    if (mem_ack_i) xa_q.push_back(mcyc_o.addr);
    if (mem_ack_i && mcyc_o.wr) wrs++;
    if (cyc > 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  // one dma request, waits for the mastership to end
  task automatic run_dma(input logic [15:0] cmd);
    int k;
    xa_q.delete();
    wrs = 0;
    wr_reg(REG_DMA_REQ, cmd);
    k = 0;
    while (!bus_req_o && k < 20) begin
      @(posedge clk_sys_i);
      k++;
    end
    while (bus_req_o && k < 3000) begin
      @(posedge clk_sys_i);
      k++;
    end
    // let the synced grant fall so the sequencer is idle for the next request
    repeat (4) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd_reg(REG_CSR_MAIN, d); chk(d, MAIN_RST); // [RESET]
    rd_reg(REG_BURST_LIM, d); chk(d, BURST_LIM_RST);
    rd_reg(7'h7F, d); chk(d, 16'h0000); // [RESET]
    wr_reg(REG_SETUP_LO, 16'h1234);
    wr_reg(REG_SETUP_HI, 16'h0056);
    xa_q.delete();
    grants = 0;
    wr_reg(REG_CSR_MAIN, 16'h0043);
    n = 0;
    d = 16'h0000;
    while (!d[B_SETUP_DONE] && n < 400) begin
      rd_reg(REG_CSR_MAIN, d);
      n++;
    end
    chk(d[B_SETUP_DONE], 1'b1);
    chk(grants, 3);
    chk(xa_q.size(), 12);
    for (int i = 0; i < 12 && i < xa_q.size(); i++) chk(xa_q[i], 24'h561234 + 2 * i);
    chk(irq_o, 1'b1);
    wr_reg(REG_CSR_MAIN, 16'h0140);
    rd_reg(REG_CSR_MAIN, d); chk(irq_o, 1'b0);
    // direct setup, setup request left clear
    wr_reg(REG_TX_BASE_LO, 16'h0A08);
    wr_reg(REG_TX_BASE_HI, 16'h0000);
    wr_reg(REG_TX_RX_RING_LENGTH_CODE, 16'h0002);
    // own ring pointers back at base after restart
    wr_reg(REG_CSR_MAIN, 16'h0044);
    wr_reg(REG_MODE, 16'h0000);
    wr_reg(REG_CSR_MAIN, 16'h0042);
    rd_reg(REG_TX_CUR_LO, d); chk(d, 16'h0A08);
    rd_reg(REG_CSR_MAIN, d); chk(d[5:4], 2'b11);
    run_dma(16'hA025);
    chk(xa_q.size(), 1);
    chk(wrs, 1);
    chk(mem_wdata_o, 16'h000A);
    chk(xa_q.size() > 0 ? xa_q[0] : 24'h0, 24'h000A08);
    rd_reg(REG_TX_CUR_LO, d); chk(d, 16'h0A10);
    run_dma(16'hA025);
    rd_reg(REG_TX_CUR_LO, d); chk(d, 16'h0A08);
    // slow memory under a short burst
    slow <= 1'b1;
    wr_reg(REG_BURST_LIM, 16'h0003);
    run_dma(16'h0002);
    chk(xa_q.size(), 3);
    chk(xa_q.size() == 3 ? xa_q[2] - xa_q[0] : 24'h0, 24'h000004);
    slow <= 1'b0;
    wr_reg(REG_FEATURE, 16'h4000);
    run_dma(16'h0002);
    chk(xa_q.size(), 1);
    fifo_level_i <= 8'h10;
    run_dma(16'h0006);
    chk(xa_q.size(), 1);
    @(posedge clk_sys_i) tx_transmit_underflow_flag_i <= 1'b1;
    @(posedge clk_sys_i) tx_transmit_underflow_flag_i <= 1'b0;
    rd_reg(REG_CSR_MAIN, d); chk(d[5:4], 2'b10);
    @(posedge clk_sys_i) mem_err_i <= 1'b1;
    @(posedge clk_sys_i) mem_err_i <= 1'b0;
    rd_reg(REG_CSR_MAIN, d); chk(d[5:4], 2'b00);
    chk(irq_o, 1'b1);
    wr_reg(REG_CSR_MAIN, 16'h0844);
    wr_reg(REG_MODE, 16'h0001);
    wr_reg(REG_CSR_MAIN, 16'h0042);
    rd_reg(REG_CSR_MAIN, d); chk(d[5:4], 2'b10);
    chk(irq_o, 1'b0);
    @(posedge clk_sys_i) slv_sel_i <= 1'b1;
    #1 chk(iochrdy_o, 1'b0);
    repeat (6) @(posedge clk_sys_i);
    #1 chk(iochrdy_o, 1'b1);
    @(posedge clk_sys_i) slv_sel_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule
`default_nettype wire
